/* File: pkg/serial_pin_pkg.sv */
package serial_pin_pkg;

    // Width of the sticky status vector that the host reads and clears.
    localparam int STATUS_W = 8;

    // Frame layout: one command byte, then one data byte, most significant bit first.
    localparam int CMD_BITS   = 8;
    localparam int FRAME_BITS = 16;
    localparam int BIT_CNT_W  = 5;

    // Command byte fields: top bit asks for a read, the rest is the address.
    localparam int CMD_READ_BIT = 7;

    // Internal register addresses reached through the serial port.
    localparam logic [6:0] ADDR_STATUS = 7'h00;
    localparam logic [6:0] ADDR_CTRL   = 7'h01;

    // Control register fields and its value after reset.
    localparam int         CTRL_OUT_EN_BIT     = 0;
    localparam int         CTRL_THREE_WIRE_BIT = 1;
    localparam logic [7:0] CTRL_RESET          = 8'h01;

    // Status register value after reset.
    localparam logic [STATUS_W-1:0] STATUS_RESET = 8'h00;

    // Pin synchroniser lanes and their values after reset.
    localparam int         PIN_W          = 5;
    localparam int         PIN_RESET_N    = 0;
    localparam int         PIN_STRAP      = 1;
    localparam int         PIN_ADDR_ZERO  = 2;
    localparam int         PIN_ADDR_ONE   = 3;
    localparam int         PIN_SDA        = 4;
    localparam logic [4:0] PIN_SYNC_RESET = 5'h17;

    // Bit counter value at the start of a frame.
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;

    // Host port personality chosen by the strap.
    typedef enum logic {
        MODE_SPI,
        MODE_I2C
    } host_mode_type;

    // Phase of a serial frame on the link side.
    typedef enum logic [1:0] {
        PH_CMD,
        PH_DATA,
        PH_DONE
    } frame_phase_type;

    // A completed write, passed from the link domain to the core domain.
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } link_write_type;

endpackage

/* File: src/spi_link_engine.sv */
`timescale 1ns/100ps
module spi_link_engine
    import serial_pin_pkg::*;
(
    // Link clock and resets.
    input  wire logic                i_sclk,
    input  wire logic                i_frame_idle,
    input  wire logic                i_dev_rst,
    // Serial data from the host.
    input  wire logic                i_data_in,
    // Core-domain levels returned on reads.
    input  wire logic [STATUS_W-1:0] i_status,
    input  wire logic [7:0]          i_ctrl,
    // Read data and its drive window.
    output logic                     o_read_out,
    output logic                     o_read_phase,
    // Completed write word and its toggle.
    output link_write_type           o_wr,
    output logic                     o_wr_toggle
);

    frame_phase_type       phase_r,   phase_nxt;    // Frame phase.
    logic [BIT_CNT_W-1:0]  cnt_r,     cnt_nxt;      // Bits taken so far.
    logic [7:0]            cmd_r,     cmd_nxt;      // Command byte being shifted in.
    logic [7:0]            rx_r,      rx_nxt;       // Data byte being shifted in.
    logic [7:0]            tx_r,      tx_nxt;       // Read byte being shifted out.
    logic                  rdph_r,    rdph_nxt;     // Read data window.
    logic [STATUS_W-1:0]   st_s1_r,   st_s2_r;      // Status synchroniser.
    logic [7:0]            ct_s1_r,   ct_s2_r;      // Control synchroniser.
    link_write_type        wr_r,      wr_nxt;       // Held write word.
    logic                  tog_r,     tog_nxt;      // Write event toggle.
    logic                  out_r;                   // Launched read bit.
    logic [7:0]            rd_byte;                 // Byte picked for a read.

    // Frame sequencing: command byte, then data byte in or out.
    always_comb begin
        phase_nxt = phase_r;
        cnt_nxt   = cnt_r;
        cmd_nxt   = cmd_r;
        rx_nxt    = rx_r;
        tx_nxt    = tx_r;
        rdph_nxt  = rdph_r;
        rd_byte   = 8'h00;
        // Unknown addresses read as zero.
        // The address is the low seven command bits; the read bit sits above them.
        if ({cmd_r[5:0], i_data_in} == ADDR_STATUS) begin
            rd_byte = 8'(st_s2_r);
        end
        if (cmd_r[5:0] == ADDR_CTRL[6:1] && i_data_in == ADDR_CTRL[0]) begin
            rd_byte = ct_s2_r;
        end
        unique case (phase_r)
            PH_CMD: begin
                cmd_nxt = {cmd_r[6:0], i_data_in};
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == 5'(CMD_BITS - 1)) begin
                    phase_nxt = PH_DATA;
                    // The whole command is known at this edge.
                    rdph_nxt  = cmd_r[CMD_READ_BIT - 1];
                    tx_nxt    = rd_byte;
                end
            end
            PH_DATA: begin
                rx_nxt  = {rx_r[6:0], i_data_in};
                tx_nxt  = {tx_r[6:0], 1'b0};
                cnt_nxt = cnt_r + 5'h01;
                if (cnt_r == 5'(FRAME_BITS - 1)) begin
                    phase_nxt = PH_DONE;
                    rdph_nxt  = 1'b0;
                end
            end
            PH_DONE: begin
                // Extra clocks after a full frame are ignored.
            end
            default: begin
                // The unused phase code falls back to a fresh command byte.
                phase_nxt = PH_CMD;
            end
        endcase
    end

    // Frame state is cleared whenever the host deselects the device.
    always_ff @(posedge i_sclk or posedge i_frame_idle) begin
        if (i_frame_idle) begin
            phase_r <= PH_CMD;
            cnt_r   <= BIT_CNT_RESET;
            cmd_r   <= 8'h00;
            rx_r    <= 8'h00;
            tx_r    <= 8'h00;
            rdph_r  <= 1'b0;
            st_s1_r <= STATUS_RESET;
            st_s2_r <= STATUS_RESET;
            ct_s1_r <= CTRL_RESET;
            ct_s2_r <= CTRL_RESET;
        end else begin
            phase_r <= phase_nxt;
            cnt_r   <= cnt_nxt;
            cmd_r   <= cmd_nxt;
            rx_r    <= rx_nxt;
            tx_r    <= tx_nxt;
            rdph_r  <= rdph_nxt;
            // Levels from the core settle during the command byte.
            st_s1_r <= i_status;
            st_s2_r <= st_s1_r;
            ct_s1_r <= i_ctrl;
            ct_s2_r <= ct_s1_r;
        end
    end

    // A write is handed over on the last data bit by flipping the toggle.
    always_comb begin
        wr_nxt  = wr_r;
        tog_nxt = tog_r;
        if (phase_r == PH_DATA && cnt_r == 5'(FRAME_BITS - 1) && !cmd_r[CMD_READ_BIT]) begin
            wr_nxt  = '{addr: cmd_r[6:0], data: {rx_r[6:0], i_data_in}};
            tog_nxt = ~tog_r;
        end
    end

    // The toggle survives deselection so that the core sees every write once.
    always_ff @(posedge i_sclk or posedge i_dev_rst) begin
        if (i_dev_rst) begin
            wr_r  <= '0;
            tog_r <= 1'b0;
        end else begin
            wr_r  <= wr_nxt;
            tog_r <= tog_nxt;
        end
    end

    // Read bits launch on the falling edge so the host samples them on the rising edge.
    always_ff @(negedge i_sclk or posedge i_frame_idle) begin
        if (i_frame_idle) begin
            out_r <= 1'b0;
        end else begin
            out_r <= tx_r[7];
        end
    end

    assign o_read_out   = out_r;
    assign o_read_phase = rdph_r;
    assign o_wr         = wr_r;
    assign o_wr_toggle  = tog_r;

endmodule

/* File: src/serial_host_port_pins.sv */
`timescale 1ns/100ps
module serial_host_port_pins
    import serial_pin_pkg::*;
(
    // Core clock and reset.
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    // Serial clock from the host, never driven by this block.
    input  wire logic                i_sclk,
    // Strap and reset pins.
    input  wire logic                i_if_select,
    input  wire logic                i_device_reset_n,
    // Address-zero or chip-select pin.
    input  wire logic                i_addr_bit_zero_or_select_n,
    // Shared data pin.
    input  wire logic                i_sda_in,
    output logic                     o_sda_out,
    output logic                     o_sda_oe,
    // Address-one or read-data pin.
    input  wire logic                i_addr_bit_one_or_read_out,
    output logic                     o_addr_bit_one_or_read_out,
    output logic                     o_addr_bit_one_or_read_out_oe,
    // Device status events and interrupt pin.
    input  wire logic [STATUS_W-1:0] i_status_event,
    output logic                     o_status_change_irq_n,
    // Hooks for the I2C protocol engine that sits beside this block.
    input  wire logic                i_i2c_sda_pull_low,
    output logic                     o_i2c_sda_in,
    output logic [1:0]               o_bus_address,
    // Device-wide results.
    output host_mode_type            o_host_mode,
    output logic                     o_in_reset,
    output logic                     o_clk_out_enable,
    output logic [7:0]               o_ctrl,
    output logic [STATUS_W-1:0]      o_status
);

    logic [PIN_W-1:0]    pin_raw;                      // Slow pins gathered in one vector.
    logic [PIN_W-1:0]    pin_s1_r;                     // First synchroniser stage.
    logic [PIN_W-1:0]    pin_s2_r;                     // Second synchroniser stage.
    logic                rst_r,       rst_nxt;         // Device held in reset.
    host_mode_type       mode_r,      mode_nxt;        // Strap caught while in reset.
    logic [1:0]          addr_r,      addr_nxt;        // I2C address pins.
    logic [2:0]          tog_sync_r,  tog_sync_nxt;    // Write toggle crossing.
    link_write_type      wr_cap_r,    wr_cap_nxt;      // Captured write word.
    logic                wr_valid_r,  wr_valid_nxt;    // Captured word is new this cycle.
    logic [7:0]          ctrl_r,      ctrl_nxt;        // Control register.
    logic [STATUS_W-1:0] status_r,    status_nxt;      // Sticky status flags.
    logic                irq_n_r,     irq_n_nxt;       // Interrupt pin level.
    logic                clk_en_r,    clk_en_nxt;      // Clock output enable.
    logic [STATUS_W-1:0] clear_mask;                   // Flags the host clears.
    logic                frame_idle;                   // Link frame logic held idle.
    logic                read_out;                     // Read data from the link.
    logic                read_phase;                   // Read data window from the link.
    link_write_type      link_wr;                      // Write word held by the link.
    logic                link_tog;                     // Write toggle from the link.
    logic                spi_mode;                     // SPI personality in use.
    logic                three_wire;                   // SPI read data returns on the data pin.

    // Every slow pin goes through two flops before the core-domain logic looks at it; the link takes the select and data pins raw.
    assign pin_raw = {i_sda_in, i_addr_bit_one_or_read_out, i_addr_bit_zero_or_select_n,
                      i_if_select, i_device_reset_n};

    // Pin synchroniser; reset values model a floating pin: high on every lane except address-one, which resets low.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_s1_r <= PIN_SYNC_RESET;
            pin_s2_r <= PIN_SYNC_RESET;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Reset and personality: the strap is caught during reset and frozen at release.
    always_comb begin
        rst_nxt  = !pin_s2_r[PIN_RESET_N];
        mode_nxt = mode_r;
        addr_nxt = addr_r;
        if (rst_r) begin
            mode_nxt = host_mode_type'(pin_s2_r[PIN_STRAP]);
        end
        if (mode_r == MODE_I2C) begin
            // Both address pins are only sampled here, never driven.
            addr_nxt = {pin_s2_r[PIN_ADDR_ONE], pin_s2_r[PIN_ADDR_ZERO]};
        end
    end

    // Reset and personality registers; the device starts held in reset.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_r  <= 1'b1;
            mode_r <= MODE_I2C;
            addr_r <= 2'h0;
        end else begin
            rst_r  <= rst_nxt;
            mode_r <= mode_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Write crossing: the toggle is synchronised, and the word it guards is
    // already stable when its edge is seen, so it is sampled without its own sync.
    always_comb begin
        tog_sync_nxt = {tog_sync_r[1:0], link_tog};
        wr_valid_nxt = tog_sync_r[1] ^ tog_sync_r[2];
        wr_cap_nxt   = wr_cap_r;
        if (tog_sync_r[1] ^ tog_sync_r[2]) begin
            wr_cap_nxt = link_wr;
        end
    end

    // Write crossing registers follow the device reset like the link toggle does.
    always_ff @(posedge i_clk) begin
        if (i_srst || rst_r) begin
            tog_sync_r <= 3'h0;
            wr_valid_r <= 1'b0;
            wr_cap_r   <= '0;
        end else begin
            tog_sync_r <= tog_sync_nxt;
            wr_valid_r <= wr_valid_nxt;
            wr_cap_r   <= wr_cap_nxt;
        end
    end

    // Configuration and status: writes land here, events set flags.
    always_comb begin
        ctrl_nxt   = ctrl_r;
        clear_mask = '0;
        if (wr_valid_r && wr_cap_r.addr == ADDR_CTRL) begin
            ctrl_nxt = wr_cap_r.data;
        end
        if (wr_valid_r && wr_cap_r.addr == ADDR_STATUS) begin
            clear_mask = wr_cap_r.data[STATUS_W-1:0];
        end
        // An event in the same cycle as its clear keeps the flag set.
        status_nxt = (status_r & ~clear_mask) | i_status_event;
        irq_n_nxt  = !(|status_nxt);
        clk_en_nxt = ctrl_nxt[CTRL_OUT_EN_BIT];
        if (rst_r || rst_nxt) begin
            // Host writes are discarded and defaults return while in reset; the
            // defaults load at the edge that raises the reset flag, so the clock
            // enable is never seen high together with it.
            ctrl_nxt   = CTRL_RESET;
            status_nxt = STATUS_RESET;
            irq_n_nxt  = 1'b1;
            clk_en_nxt = 1'b0;
        end
    end

    // Configuration and status registers.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_r   <= CTRL_RESET;
            status_r <= STATUS_RESET;
            irq_n_r  <= 1'b1;
            clk_en_r <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            irq_n_r  <= irq_n_nxt;
            clk_en_r <= clk_en_nxt;
        end
    end

    // The link logic only runs while SPI is chosen, the device runs, and the
    // host holds select low; the raw pin is used so deselection acts at once.
    assign frame_idle = i_addr_bit_zero_or_select_n || mode_r == MODE_I2C || rst_r;

    // Serial engine on the host's clock; the clock pin is only ever an input.
    spi_link_engine u_link (
        .i_sclk       (i_sclk),
        .i_frame_idle (frame_idle),
        .i_dev_rst    (rst_r),
        .i_data_in    (i_sda_in),
        .i_status     (status_r),
        .i_ctrl       (ctrl_r),
        .o_read_out   (read_out),
        .o_read_phase (read_phase),
        .o_wr         (link_wr),
        .o_wr_toggle  (link_tog)
    );

    assign spi_mode   = mode_r == MODE_SPI;
    assign three_wire = ctrl_r[CTRL_THREE_WIRE_BIT];

    // Pin drivers. In I2C mode the data pin is open drain and pulls low only;
    // in SPI it returns read data only with 3-wire chosen, and is input only in 4-wire.
    always_comb begin
        o_sda_out = 1'b0;
        o_sda_oe  = 1'b0;
        if (!spi_mode) begin
            o_sda_oe = i_i2c_sda_pull_low && !rst_r;
        end else if (three_wire) begin
            o_sda_out = read_out;
            o_sda_oe  = read_phase;
        end
    end

    // The address-one pin becomes a push-pull data output only in 4-wire SPI.
    assign o_addr_bit_one_or_read_out    = read_out;
    assign o_addr_bit_one_or_read_out_oe = spi_mode && !three_wire && read_phase;

    // Outputs to the rest of the device.
    assign o_status_change_irq_n = irq_n_r;
    assign o_i2c_sda_in          = pin_s2_r[PIN_SDA];
    assign o_bus_address         = addr_r;
    assign o_host_mode           = mode_r;
    assign o_in_reset            = rst_r;
    assign o_clk_out_enable      = clk_en_r;
    assign o_ctrl                = ctrl_r;
    assign o_status              = status_r;

endmodule

/* File: sim/serial_host_port_pins_sva.sv */
`timescale 1ns/100ps
module serial_host_port_pins_chk
    import serial_pin_pkg::*;
(
    // Core clock and reset.
    input wire logic                i_clk,
    input wire logic                i_srst,
    // Pins seen by the block.
    input wire logic                i_device_reset_n,
    input wire logic                i_addr_bit_zero_or_select_n,
    input wire logic                i_addr_bit_one_or_read_out,
    input wire logic [STATUS_W-1:0] i_status_event,
    // Outputs of the block.
    input wire logic                o_sda_oe,
    input wire logic                o_addr_bit_one_or_read_out_oe,
    input wire logic                o_status_change_irq_n,
    input wire logic [1:0]          o_bus_address,
    input wire host_mode_type       o_host_mode,
    input wire logic                o_in_reset,
    input wire logic                o_clk_out_enable,
    input wire logic [7:0]          o_ctrl,
    input wire logic [STATUS_W-1:0] o_status
);
    // All checks live in the core domain and sleep through core reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    property p_mode_latched;
        !o_in_reset [*3] |-> $stable(o_host_mode);
    endproperty
    a_mode_latched: assert property (p_mode_latched) else $error("Mode moved outside reset.");
    property p_four_wire_input;
        o_host_mode == MODE_SPI && !o_ctrl[CTRL_THREE_WIRE_BIT] |-> !o_sda_oe;
    endproperty
    a_four_wire_input: assert property (p_four_wire_input) else $error("Data pin driven.");
    property p_i2c_a1_input;
        o_host_mode == MODE_I2C |-> !o_addr_bit_one_or_read_out_oe;
    endproperty
    a_i2c_a1_input: assert property (p_i2c_a1_input) else $error("Address pin driven.");
    // Read data only leaves on the address-one pin while selected, in 4-wire SPI.
    property p_read_window;
        o_addr_bit_one_or_read_out_oe |-> o_host_mode == MODE_SPI
            && !i_addr_bit_zero_or_select_n && !o_ctrl[CTRL_THREE_WIRE_BIT];
    endproperty
    a_read_window: assert property (p_read_window) else $error("Read pin out of frame.");
    // Pins must be steady long enough to pass the synchroniser first.
    property p_addr_strap;
        (o_host_mode == MODE_I2C && !o_in_reset && $stable(i_addr_bit_one_or_read_out)
            && $stable(i_addr_bit_zero_or_select_n)) [*4] |-> o_bus_address ==
            {i_addr_bit_one_or_read_out, i_addr_bit_zero_or_select_n};
    endproperty
    a_addr_strap: assert property (p_addr_strap) else $error("Bus address not sampled.");
    property p_irq_on_event;
        |i_status_event && !o_in_reset |=> !o_status_change_irq_n || o_in_reset;
    endproperty
    a_irq_on_event: assert property (p_irq_on_event) else $error("Interrupt not raised.");
    property p_reset_entry;
        !i_device_reset_n [*4] |-> o_in_reset;
    endproperty
    a_reset_entry: assert property (p_reset_entry) else $error("Reset pin ignored.");
    property p_reset_defaults;
        o_in_reset ##1 o_in_reset |-> o_ctrl == CTRL_RESET && o_status == STATUS_RESET;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("Defaults lost.");
    property p_clocks_off;
        o_in_reset |-> !o_clk_out_enable;
    endproperty
    a_clocks_off: assert property (p_clocks_off) else $error("Clocks on in reset.");
endmodule

bind serial_host_port_pins serial_host_port_pins_chk i_chk (.*);

/* File: sim/spi_host_model.sv */
`timescale 1ns/100ps
module spi_host_model (
    // Wire levels seen by the host.
    input  wire logic i_three_wire,
    input  wire logic i_sda_w,
    input  wire logic i_rd_w,
    // Link pins driven by the host.
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_sda,
    output logic      o_sda_oe
);
    // Half period of the 48 ns link clock.
    localparam int HALF = 24;

    // Idle: clock parked low, select high, data line released.
    initial begin
        o_sclk   = 1'b0;
        o_sel_n  = 1'b1;
        o_sda    = 1'b0;
        o_sda_oe = 1'b0;
    end

    // One frame, most significant bit first; the clock runs only inside it.
    task automatic xfer(input logic [15:0] w, input logic hold_high, output logic [7:0] rd);
        rd = 8'h00;
        o_sel_n = hold_high;
        #HALF;
        for (int i = 15; i >= 0; i--) begin
            // In 3-wire reads the host lets go of the line for the data byte.
            o_sda_oe = !(i_three_wire && w[15] && i < 8);
            o_sda = w[i];
            #HALF o_sclk = 1'b1;
            if (i < 8) begin
                rd[i] = i_three_wire ? i_sda_w : i_rd_w;
            end
            #HALF o_sclk = 1'b0;
        end
        #HALF o_sel_n = 1'b1;
        o_sda_oe = 1'b0;
    endtask
endmodule

/* File: sim/serial_host_port_pins_tb.sv */
`timescale 1ns/100ps
module serial_host_port_pins_tb
    import serial_pin_pkg::*;
();
    // Bench-driven pins and link wires.
    logic          i_clk, i_srst, if_sel, rst_n, a0, a1, pull_low, three_wire;
    logic [7:0]    ev, rd;
    logic          sclk, sel_n, h_sda, h_oe, sda_w, a1_w, sel_w;
    // Outputs of the block.
    logic          sda_out, sda_oe, a1_out, a1_oe, irq_n, i2c_sda, in_rst, clk_en;
    logic [1:0]    bus_addr;
    logic [7:0]    ctrl, status;
    host_mode_type mode;
    int            fail_count, tests_run, cycles;

    // Block output wins; the I2C pull-up holds released lines high, and a released
    // SPI line shows the inverse of the level last driven on it.
    assign sda_w = sda_oe ? sda_out : h_oe ? h_sda : if_sel ? 1'b1 : ~h_sda;
    assign a1_w  = a1_oe ? a1_out : if_sel ? a1 : ~a1_out;
    assign sel_w = if_sel ? a0 : sel_n;

    serial_host_port_pins i_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_sclk(sclk), .i_if_select(if_sel),
        .i_device_reset_n(rst_n), .i_addr_bit_zero_or_select_n(sel_w), .i_sda_in(sda_w),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_bit_one_or_read_out(a1_w),
        .o_addr_bit_one_or_read_out(a1_out), .o_addr_bit_one_or_read_out_oe(a1_oe),
        .i_status_event(ev), .o_status_change_irq_n(irq_n), .i_i2c_sda_pull_low(pull_low),
        .o_i2c_sda_in(i2c_sda), .o_bus_address(bus_addr), .o_host_mode(mode),
        .o_in_reset(in_rst), .o_clk_out_enable(clk_en), .o_ctrl(ctrl), .o_status(status));

    spi_host_model i_host (.i_three_wire(three_wire), .i_sda_w(sda_w), .i_rd_w(a1_w),
        .o_sclk(sclk), .o_sel_n(sel_n), .o_sda(h_sda), .o_sda_oe(h_oe));

    always #12.5 i_clk = ~i_clk;

    // A hung run is cut short and counted as a mismatch.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 5000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // Bench-driven inputs change 1 ns after the edge; the host model's link pins keep their own timing.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // One frame, then a gap long enough for the write to cross domains.
    task automatic spi(input logic [15:0] w, input logic hold_high);
        i_host.xfer(w, hold_high, rd);
        tick(8);
    endtask

    task automatic pulse(input logic [7:0] v);
        ev = v;
        tick(1);
        ev = 8'h00;
        tick(1);
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Reset pulse; the strap in force at release picks the mode.
    task automatic t_dev_reset(input logic strap);
        int n;
        if_sel = strap;
        rst_n = 1'b0;
        tick(5);
        check(in_rst, 1'h1);
        check(clk_en, 1'h0);
        check(ctrl, CTRL_RESET);
        check(status, STATUS_RESET);
        rst_n = 1'b1;
        n = 0;
        while (in_rst !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        tick(3);
        check(mode, strap ? MODE_I2C : MODE_SPI);
        check(clk_en, 1'h1);
    endtask

    task automatic t_i2c_pins();
        for (int v = 0; v < 4; v++) begin
            {a1, a0} = v[1:0];
            tick(5);
            check(bus_addr, v[1:0]);
            check(a1_oe, 1'h0);
        end
        pull_low = 1'b1;
        tick(4);
        check({sda_oe, sda_out, i2c_sda}, 3'h4);
        pull_low = 1'b0;
        tick(4);
        check({sda_oe, i2c_sda}, 2'h1);
    endtask

    task automatic t_spi();
        t_dev_reset(1'b0);
        spi(16'h0100, 1'b0);
        check(ctrl, 8'h00);
        spi(16'h8100, 1'b0);
        check(rd, 8'h00);
        spi(16'h0102, 1'b1);
        check(ctrl, 8'h00);
        pulse(8'h05);
        check({irq_n, status}, 9'h005);
        spi(16'h8000, 1'b0);
        check(rd, 8'h05);
        spi(16'h0001, 1'b0);
        check({irq_n, status}, 9'h004);
        spi(16'h0004, 1'b0);
        check({irq_n, status}, 9'h100);
        spi(16'h0103, 1'b0);
        three_wire = 1'b1;
        spi(16'h8100, 1'b0);
        check(rd, 8'h03);
        three_wire = 1'b0;
        pulse(8'h80);
        t_dev_reset(1'b1);
    endtask

    initial begin
        i_clk = 1'b0;
        i_srst = 1'b1;
        {if_sel, rst_n, a0, a1, pull_low, three_wire} = 6'h38;
        ev = 8'h00;
        tick(3);
        i_srst = 1'b0;
        tick(4);
        check(mode, MODE_I2C);
        check({irq_n, ctrl}, {1'b1, CTRL_RESET});
        t_i2c_pins();
        if_sel = 1'b0;
        tick(6);
        check(mode, MODE_I2C);
        t_spi();
        close_out();
    end
endmodule
